// ---- logic/psrc_pkg.sv ----
// Purpose: constants and types for the peripheral software reset control block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes:   reset control bits follow the capability masks given at the ports
package psrc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] PSRC_BASE_ADDR  = 32'h400FE000;
  localparam logic [11:0] PSRC_OFS_CTRL_A = 12'h040;
  localparam logic [11:0] PSRC_OFS_CTRL_B = 12'h044;
  localparam logic [31:0] PSRC_RST_CTRL_A = 32'h00000000;
  localparam logic [31:0] PSRC_RST_CTRL_B = 32'h00000000;

  // ----------------------------------------
  // field positions, register a
  // ----------------------------------------
  localparam int PSRC_A_CAN  = 24;
  localparam int PSRC_A_ADC  = 16;
  localparam int PSRC_A_HBRN = 6;
  localparam int PSRC_A_WDOG = 3;

  // ----------------------------------------
  // field positions, register b
  // ----------------------------------------
  localparam int PSRC_B_COMP = 24;
  localparam int PSRC_B_GPC2 = 18;
  localparam int PSRC_B_GPC1 = 17;
  localparam int PSRC_B_GPC0 = 16;
  localparam int PSRC_B_TWI  = 12;
  localparam int PSRC_B_SSER = 4;
  localparam int PSRC_B_ASER = 0;

  // implemented bits of each register
  localparam logic [31:0] PSRC_IMPL_A = 32'h01010048;
  localparam logic [31:0] PSRC_IMPL_B = 32'h01071011;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [31:0] prdata;
  } psrc_state_t;

  typedef struct packed {
    logic controller_area_unit_reset;
    logic adc_unit_reset;
    logic hibernation_unit_reset;
    logic watchdog_unit_reset;
    logic comparator_unit_reset;
    logic gp_counter_two_reset;
    logic gp_counter_one_reset;
    logic gp_counter_zero_reset;
    logic two_wire_unit_reset;
    logic sync_serial_unit_reset;
    logic async_serial_unit_reset;
  } psrc_resets_t;

endpackage

// ---- logic/psrc_top.sv ----
// Purpose: two software reset control registers behind an apb slave
// Assumes: paddr is the full byte address; capability masks are static levels
// Notes:   zero wait states; unmapped addresses read zero and answer pslverr
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

module psrc_top (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // capability masks
  input  wire logic [31:0]           capability_mask_one,
  input  wire logic [31:0]           capability_mask_two,
  // unit resets
  output psrc_pkg::psrc_resets_t     unit_resets
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  psrc_pkg::psrc_state_t state_r;
  psrc_pkg::psrc_state_t state_nxt;

  logic        hit_a;
  logic        hit_b;
  logic        in_base;
  logic        acc;
  logic [31:0] wmask;
  logic [31:0] en_a;
  logic [31:0] en_b;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // upper address bits must match so aliases elsewhere do not hit
  assign in_base = (paddr[31:12] == psrc_pkg::PSRC_BASE_ADDR[31:12]);
  assign hit_a   = in_base && (paddr[11:0] == psrc_pkg::PSRC_OFS_CTRL_A);
  assign hit_b   = in_base && (paddr[11:0] == psrc_pkg::PSRC_OFS_CTRL_B);
  assign acc     = psel && penable;

  // byte strobes widened to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_strb
      assign wmask[8*g +: 8] = {8{pstrb[g]}};
    end
  endgenerate

  // capability and implemented bits both gate the write
  assign en_a = wmask & capability_mask_one & psrc_pkg::PSRC_IMPL_A;
  assign en_b = wmask & capability_mask_two & psrc_pkg::PSRC_IMPL_B;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (acc && pwrite && hit_a) begin
      state_nxt.ctrl_a = (state_r.ctrl_a & ~en_a) | (pwdata & en_a);
    end
    if (acc && pwrite && hit_b) begin
      state_nxt.ctrl_b = (state_r.ctrl_b & ~en_b) | (pwdata & en_b);
    end
    if (psel && !penable && !pwrite) begin
      if (hit_a) begin
        state_nxt.prdata = state_r.ctrl_a;
      end else if (hit_b) begin
        state_nxt.prdata = state_r.ctrl_b;
      end else begin
        state_nxt.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r.ctrl_a <= psrc_pkg::PSRC_RST_CTRL_A;
      state_r.ctrl_b <= psrc_pkg::PSRC_RST_CTRL_B;
      state_r.prdata <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // read data latched in setup, so a write in the same access is not seen
  assign prdata  = state_r.prdata;
  assign pready  = 1'b1;
  assign pslverr = acc && !(hit_a || hit_b);

  // ----------------------------------------
  // unit resets
  // ----------------------------------------
  assign unit_resets.controller_area_unit_reset =
    state_r.ctrl_a[psrc_pkg::PSRC_A_CAN];
  assign unit_resets.adc_unit_reset             =
    state_r.ctrl_a[psrc_pkg::PSRC_A_ADC];
  assign unit_resets.hibernation_unit_reset     =
    state_r.ctrl_a[psrc_pkg::PSRC_A_HBRN];
  assign unit_resets.watchdog_unit_reset        =
    state_r.ctrl_a[psrc_pkg::PSRC_A_WDOG];
  assign unit_resets.comparator_unit_reset      =
    state_r.ctrl_b[psrc_pkg::PSRC_B_COMP];
  assign unit_resets.gp_counter_two_reset       =
    state_r.ctrl_b[psrc_pkg::PSRC_B_GPC2];
  assign unit_resets.gp_counter_one_reset       =
    state_r.ctrl_b[psrc_pkg::PSRC_B_GPC1];
  assign unit_resets.gp_counter_zero_reset      =
    state_r.ctrl_b[psrc_pkg::PSRC_B_GPC0];
  assign unit_resets.two_wire_unit_reset        =
    state_r.ctrl_b[psrc_pkg::PSRC_B_TWI];
  assign unit_resets.sync_serial_unit_reset     =
    state_r.ctrl_b[psrc_pkg::PSRC_B_SSER];
  assign unit_resets.async_serial_unit_reset    =
    state_r.ctrl_b[psrc_pkg::PSRC_B_ASER];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_mask_a;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_a)
        |=> ((state_r.ctrl_a & ~$past(en_a)) == ($past(state_r.ctrl_a) & ~$past(en_a)));
  endproperty
  a_mask_a: assert property (p_mask_a) else $error("masked bit of reg a changed");

  property p_mask_b;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_b)
        |=> ((state_r.ctrl_b & ~$past(en_b)) == ($past(state_r.ctrl_b) & ~$past(en_b)));
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("masked bit of reg b changed");

  property p_write_a;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_a)
        |=> ((state_r.ctrl_a & $past(en_a)) == ($past(pwdata) & $past(en_a)));
  endproperty
  a_write_a: assert property (p_write_a) else $error("write to reg a lost");

  property p_can;
    @(posedge pclk) disable iff (!presetn)
      unit_resets.controller_area_unit_reset == state_r.ctrl_a[24];
  endproperty
  a_can: assert property (p_can) else $error("can reset not from bit 24");

  property p_wiring_a;
    @(posedge pclk) disable iff (!presetn)
      (unit_resets.hibernation_unit_reset == state_r.ctrl_a[6])
      && (unit_resets.watchdog_unit_reset == state_r.ctrl_a[3])
      && (unit_resets.adc_unit_reset == state_r.ctrl_a[16]);
  endproperty
  a_wiring_a: assert property (p_wiring_a) else $error("reg a unit reset wiring wrong");

  property p_timers;
    @(posedge pclk) disable iff (!presetn)
      {unit_resets.gp_counter_two_reset, unit_resets.gp_counter_one_reset,
       unit_resets.gp_counter_zero_reset} == state_r.ctrl_b[18:16];
  endproperty
  a_timers: assert property (p_timers) else $error("timer resets wrong");

  property p_serial;
    @(posedge pclk) disable iff (!presetn)
      (unit_resets.async_serial_unit_reset == state_r.ctrl_b[0])
      && (unit_resets.sync_serial_unit_reset == state_r.ctrl_b[4])
      && (unit_resets.two_wire_unit_reset == state_r.ctrl_b[12])
      && (unit_resets.comparator_unit_reset == state_r.ctrl_b[24]);
  endproperty
  a_serial: assert property (p_serial) else $error("reg b unit reset wiring wrong");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      ((state_r.ctrl_a & ~psrc_pkg::PSRC_IMPL_A) == 32'h00000000)
      && ((state_r.ctrl_b & ~psrc_pkg::PSRC_IMPL_B) == 32'h00000000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_read_b;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_b) |=> (prdata == $past(state_r.ctrl_b));
  endproperty
  a_read_b: assert property (p_read_b) else $error("read of reg b wrong");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !(acc && pwrite) |=> $stable(state_r.ctrl_a) && $stable(state_r.ctrl_b);
  endproperty
  a_hold: assert property (p_hold) else $error("reset bit moved without write");

  // ----------------------------------------
  // bus, reset and release checks
  // ----------------------------------------
  property p_write_b;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_b)
        |=> ((state_r.ctrl_b & $past(en_b)) == ($past(pwdata) & $past(en_b)));
  endproperty
  a_write_b: assert property (p_write_b) else $error("write to reg b lost");

  property p_read_a;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_a) |=> (prdata == $past(state_r.ctrl_a));
  endproperty
  a_read_a: assert property (p_read_a) else $error("read of reg a wrong");

  property p_read_none;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && !hit_a && !hit_b) |=> (prdata == 32'h00000000);
  endproperty
  a_read_none: assert property (p_read_none) else $error("unmapped read not zero");

  property p_rdata_hold;
    @(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      acc |-> (pslverr == (
        (paddr != {psrc_pkg::PSRC_BASE_ADDR[31:12], psrc_pkg::PSRC_OFS_CTRL_A}) &&
        (paddr != {psrc_pkg::PSRC_BASE_ADDR[31:12], psrc_pkg::PSRC_OFS_CTRL_B})));
  endproperty
  a_slverr: assert property (p_slverr) else $error("error answer wrong");

  property p_unmapped_write;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && !hit_a && !hit_b)
        |=> ($stable(state_r.ctrl_a) && $stable(state_r.ctrl_b));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  property p_reset_a;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (state_r.ctrl_a == 32'h00000000);
  endproperty
  a_reset_a: assert property (p_reset_a) else $error("reg a not clear after reset");

  property p_reset_b;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> ((state_r.ctrl_b == 32'h00000000)
                          && (unit_resets == 11'h000));
  endproperty
  a_reset_b: assert property (p_reset_b) else $error("reg b not clear after reset");

  // a bit may only rise where its capability bit allowed the write
  property p_rise_a;
    @(posedge pclk) disable iff (!presetn)
      ((state_r.ctrl_a & ~$past(state_r.ctrl_a) & ~$past(capability_mask_one))
       == 32'h00000000);
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("reg a bit set without capability");

  property p_rise_b;
    @(posedge pclk) disable iff (!presetn)
      ((state_r.ctrl_b & ~$past(state_r.ctrl_b) & ~$past(capability_mask_two))
       == 32'h00000000);
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("reg b bit set without capability");

  property p_unit_can;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_a && en_a[psrc_pkg::PSRC_A_CAN])
        |=> (unit_resets.controller_area_unit_reset == $past(pwdata[psrc_pkg::PSRC_A_CAN]));
  endproperty
  a_unit_can: assert property (p_unit_can) else $error("can reset not following write");

  property p_unit_wdog;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_a && en_a[psrc_pkg::PSRC_A_WDOG])
        |=> (unit_resets.watchdog_unit_reset == $past(pwdata[psrc_pkg::PSRC_A_WDOG]));
  endproperty
  a_unit_wdog: assert property (p_unit_wdog) else $error("watchdog reset not following");

  property p_unit_twi;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_b && en_b[psrc_pkg::PSRC_B_TWI])
        |=> (unit_resets.two_wire_unit_reset == $past(pwdata[psrc_pkg::PSRC_B_TWI]));
  endproperty
  a_unit_twi: assert property (p_unit_twi) else $error("two-wire reset not following");

  property p_unit_aser;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && hit_b && en_b[psrc_pkg::PSRC_B_ASER])
        |=> (unit_resets.async_serial_unit_reset == $past(pwdata[psrc_pkg::PSRC_B_ASER]));
  endproperty
  a_unit_aser: assert property (p_unit_aser) else $error("serial reset not following");

endmodule

// ---- tb/psrc_tb.sv ----
// Purpose: self-checking bench for the software reset control block
// Assumes: masks held still between register clears; pready awaited, never counted
// Notes:   random traffic from a fixed seed plus walking bits, unmapped and reset cases
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0]            paddr, pwdata, prdata, capability_mask_one, capability_mask_two;
  logic [31:0]            ra, rb, rd;
  logic [3:0]             pstrb;
  logic [31:0]            bad_addr [4];
  psrc_pkg::psrc_resets_t unit_resets;
  int                     miscompares, compares, seed, i;

  psrc_top psrc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capability_mask_one(capability_mask_one),
    .capability_mask_two(capability_mask_two), .unit_resets(unit_resets));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] bmask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // unit order follows the struct, msb first
  function automatic logic [31:0] units(input logic [31:0] a, input logic [31:0] b);
    return {21'h0, a[24], a[16], a[6], a[3], b[24], b[18], b[17], b[16], b[12], b[4], b[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic b, input logic [31:0] v, input logic [3:0] s);
    logic [31:0] m;
    m = bmask(s) & (b ? capability_mask_two & psrc_pkg::PSRC_IMPL_B
                      : capability_mask_one & psrc_pkg::PSRC_IMPL_A);
    apb(1'b1, 32'h400FE000 + (b ? 32'h044 : 32'h040), v, s);
    if (b) rb = (rb & ~m) | (v & m);
    else ra = (ra & ~m) | (v & m);
  endtask

  task automatic check_all;
    apb(1'b0, 32'h400FE040, 32'h0, 4'h0);
    chk(rd, ra);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 32'h400FE044, 32'h0, 4'h0);
    chk(rd, rb);
    chk({31'h0, err}, 32'h0);
    chk(units(ra, rb), {21'h0, unit_resets});
  endtask

  // clear both with full masks, then load new masks
  task automatic reload(input logic [31:0] m1, input logic [31:0] m2);
    capability_mask_one <= 32'hFFFFFFFF;
    capability_mask_two <= 32'hFFFFFFFF;
    @(posedge pclk);
    wr(1'b0, 32'h0, 4'hF);
    wr(1'b1, 32'h0, 4'hF);
    capability_mask_one <= m1;
    capability_mask_two <= m2;
    @(posedge pclk);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    bad_addr = '{32'h400FE048, 32'h500FE040, 32'h400FE000, 32'h400FF044};
    capability_mask_one = 32'hFFFFFFFF;
    capability_mask_two = 32'hFFFFFFFF;
    presetn = 1'b0;
    seed = 32'hD2D5;
    ra = 32'h0;
    rb = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_all;
    $display("test reset values done");
    for (i = 0; i < 32; i++) begin
      wr(1'b0, 32'h1 << i, 4'hF);
      wr(1'b1, 32'h1 << i, 4'hF);
      check_all;
    end
    $display("test walking bits done");
    for (i = 0; i < 60; i++) begin
      if (i % 10 == 0) reload($random(seed), $random(seed));
      wr(i[0], $random(seed), 4'($random(seed)));
      check_all;
    end
    $display("test masked writes done");
    reload(32'hFFFFFFFF, 32'hFFFFFFFF);
    wr(1'b0, 32'hFFFFFFFF, 4'hF);
    wr(1'b1, 32'hFFFFFFFF, 4'hF);
    foreach (bad_addr[k]) begin
      apb(1'b1, bad_addr[k], 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, bad_addr[k], 32'h0, 4'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
    end
    check_all;
    $display("test unmapped addresses done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ra = 32'h0;
    rb = 32'h0;
    check_all;
    $display("test second reset done");
    stop_test();
  end

  // about 340 accesses of three cycles fit well inside this span
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
endmodule
